// [common/dma_port_consts.vh]
// constants of the user-device dma request port
// assumes byte addresses on a 32-bit axi4-lite register bus
`ifndef DMA_PORT_CONSTS_VH
`define DMA_PORT_CONSTS_VH

// register byte offsets
`define OFS_CONTROL      5'h00
`define OFS_WORD_COUNT   5'h04
`define OFS_BUS_ADDR     5'h08
`define OFS_INPUT_DATA   5'h0C
`define OFS_READ_DATA    5'h10
`define OFS_IRQ_STATUS   5'h14
`define OFS_IRQ_MASK     5'h18

// control register fields
`define CTL_GO_BIT       0
`define CTL_READY_BIT    7
`define CTL_BUSY_BIT     8
`define CTL_STATUS_LSB   9
`define CTL_OVERLAP_BIT  12
`define CTL_USER_ATTENTION_BIT     13
`define CTL_BURST_BIT    14
`define CTL_ERROR_BIT    15

// interrupt status fields
`define IRQ_DONE_BIT     0
`define IRQ_ERROR_BIT    1
`define IRQ_COUNT_BIT    2
`define IRQ_WIDTH        3

// cycle type codes {high, low}
`define CYC_WORD_READ    2'h0
`define CYC_READ_PAUSE   2'h1
`define CYC_WORD_WRITE   2'h2
`define CYC_BYTE_WRITE   2'h3

// widths and reset values
`define DATA_W           16
`define ADDR_W           18
`define ADDR_STEP        18'h00002
`define WC_RESET         16'h0000
`define ADDR_RESET       18'h00000

// axi responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// [core/host_cycle_engine.v]
// host-bus mastership and single cycle sequencer
// assumes the host bus grants with a level and ends a cycle with a done pulse
`include "dma_port_consts.vh"

module host_cycle_engine (
   input  wire clk,
   input  wire rst,
   input  wire start,
   input  wire burst,
   input  wire abort,
   input  wire grant,
   input  wire done,
   output reg  bus_req_r,
   output reg  cycle_r,
   output reg  finish_r
);

localparam E_IDLE = 2'h0;
localparam E_REQ  = 2'h1;
localparam E_CYC  = 2'h2;

reg [1:0] state_r;

////////////////////////////////////////////////////////////////////////////////
always @(posedge clk or posedge rst) begin
   if (rst) begin
      state_r   <= E_IDLE;
      bus_req_r <= 1'b0;
      cycle_r   <= 1'b0;
      finish_r  <= 1'b0;
   end else begin
      finish_r <= 1'b0;
      case (state_r)
         E_IDLE: begin
            if (start && bus_req_r && grant) begin
               // still master from the last burst cycle: no new request
               cycle_r <= 1'b1; // R13
               state_r <= E_CYC;
            end else if (start) begin
               bus_req_r <= 1'b1;
               state_r   <= E_REQ;
            end else if (!burst || abort) begin
               bus_req_r <= 1'b0;
            end
         end
         E_REQ: begin
            if (grant) begin
               cycle_r <= 1'b1;
               state_r <= E_CYC;
            end
         end
         E_CYC: begin
            if (done) begin
               cycle_r   <= 1'b0;
               finish_r  <= 1'b1;
               bus_req_r <= burst && !abort; // R13
               state_r   <= E_IDLE;
            end
         end
         default: begin
            state_r   <= E_IDLE;
            bus_req_r <= 1'b0;
            cycle_r   <= 1'b0;
         end
      endcase
   end
end

endmodule // host_cycle_engine

// [core/dma_request_port.v]
// user-device side of a 16-bit parallel dma port with axi4-lite registers
// assumes user pins and host-bus handshakes are synchronous to MCLK
//
// Summary of operation
// [R1] input data captured into input data buffer
// [R2] cycle type pins pick read/pause/write/byte
// [R3] either request pin counts as one request
// [R4] attention sets error after current cycle
// [R5] three status pins readable, otherwise ignored
// [R6] word count advances only when enabled
// [R7] user negates count enable on pause/even byte
// [R8] bus address advances only when enabled
// [R9] user holds address enable low to repeat
// [R10] user negates address enable for pause/even
// [R11] low address pin drives host address bit0
// [R12] user negates low address for word sequences
// [R13] burst request held keeps bus mastership
// [R14] request while busy flags overlap error
// [R15] busy high during cycle, low after
// [R16] enabled address advance steps by two
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`include "dma_port_consts.vh"

module dma_request_port (
   input  wire                 MCLK,
   input  wire                 RST,
   // axi4-lite slave
   input  wire [4:0]           S_AXI_AWADDR,
   input  wire                 S_AXI_AWVALID,
   output reg                  S_AXI_AWREADY,
   input  wire [31:0]          S_AXI_WDATA,
   input  wire [3:0]           S_AXI_WSTRB,
   input  wire                 S_AXI_WVALID,
   output reg                  S_AXI_WREADY,
   output reg  [1:0]           S_AXI_BRESP,
   output reg                  S_AXI_BVALID,
   input  wire                 S_AXI_BREADY,
   input  wire [4:0]           S_AXI_ARADDR,
   input  wire                 S_AXI_ARVALID,
   output reg                  S_AXI_ARREADY,
   output reg  [31:0]          S_AXI_RDATA,
   output reg  [1:0]           S_AXI_RRESP,
   output reg                  S_AXI_RVALID,
   input  wire                 S_AXI_RREADY,
   // user device
   input  wire [15:0]          USER_INPUT_DATA,
   input  wire                 CYCLE_TYPE_BIT_LOW,
   input  wire                 CYCLE_TYPE_BIT_HIGH,
   input  wire                 CYCLE_REQUEST_FIRST,
   input  wire                 CYCLE_REQUEST_SECOND,
   input  wire                 USER_ATTENTION,
   input  wire [2:0]           USER_STATUS,
   input  wire                 COUNT_ADVANCE_ENABLE,
   input  wire                 ADDRESS_ADVANCE_ENABLE,
   input  wire                 BYTE_ADDRESS_LOW_BIT,
   input  wire                 BURST_REQUEST_N,
   output reg                  BUSY,
   // host bus master side
   output wire                 DMA_BUS_REQUEST,
   input  wire                 HOST_GRANT,
   output wire                 HOST_CYCLE,
   output reg  [1:0]           HOST_CYCLE_TYPE,
   output reg  [17:0]          HOST_ADDR,
   output reg  [15:0]          HOST_WDATA,
   input  wire [15:0]          HOST_RDATA,
   input  wire                 HOST_DONE,
   output reg                  IRQ
);

////////////////////////////////////////////////////////////////////////////////
// register state
reg  [15:0]          input_data_buffer_r;
reg  [15:0]          read_data_r;
reg  [15:0]          word_count_register_r;
reg  [17:0]          bus_addr_r;
reg                  run_r;
reg                  user_attention_flag_r;
reg                  overlapping_request_error_r;
reg                  req_prev_r;
reg  [1:0]           cyc_type_r;
reg                  cnt_en_r;
reg                  adr_en_r;
reg                  low_bit_r;
reg  [2:0]           irq_status_r;
reg  [2:0]           irq_mask_r;
reg                  start_r;

// axi write side holding
reg  [4:0]           aw_addr_r;
reg                  aw_have_r;
reg  [31:0]          w_data_r;
reg  [3:0]           w_strb_r;
reg                  w_have_r;

wire                 finish;
wire                 request_level;
wire                 request_edge;
wire                 error_now;
wire                 accept;
wire                 wr_fire;
wire                 burst_held;
wire [15:0]          wc_next;
wire [31:0]          merged;

////////////////////////////////////////////////////////////////////////////////
// helpers
function [31:0] merge_strobe;
   input [31:0] old_val;
   input [31:0] new_val;
   input [3:0]  strb;
   integer i;
   begin
      merge_strobe = old_val;
      for (i = 0; i < 4; i = i + 1) begin
         if (strb[i]) begin
            merge_strobe[i*8 +: 8] = new_val[i*8 +: 8];
         end
      end
   end
endfunction

function mapped;
   input [4:0] a;
   begin
      mapped = (a == `OFS_CONTROL) || (a == `OFS_WORD_COUNT) ||
               (a == `OFS_BUS_ADDR) || (a == `OFS_INPUT_DATA) ||
               (a == `OFS_READ_DATA) || (a == `OFS_IRQ_STATUS) ||
               (a == `OFS_IRQ_MASK);
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// user request decode
assign request_level = CYCLE_REQUEST_FIRST | CYCLE_REQUEST_SECOND; // R3
// edge, so a request held high is not counted twice
assign request_edge  = request_level && !req_prev_r;
assign error_now     = user_attention_flag_r || overlapping_request_error_r;
assign accept        = request_edge && run_r && !BUSY && !error_now;
assign burst_held    = !BURST_REQUEST_N; // R13
assign wr_fire       = aw_have_r && w_have_r && !S_AXI_BVALID;
assign wc_next       = word_count_register_r + 16'h0001;
assign merged        = merge_strobe((aw_addr_r == `OFS_BUS_ADDR) ? {14'h0000, bus_addr_r} :
                                    {16'h0000, word_count_register_r}, w_data_r, w_strb_r);

host_cycle_engine u_engine (
   .clk       (MCLK),
   .rst       (RST),
   .start     (start_r),
   .burst     (burst_held),
   .abort     (error_now),
   .grant     (HOST_GRANT),
   .done      (HOST_DONE),
   .bus_req_r (DMA_BUS_REQUEST),
   .cycle_r   (HOST_CYCLE),
   .finish_r  (finish)
);

////////////////////////////////////////////////////////////////////////////////
// transfer datapath
always @(posedge MCLK or posedge RST) begin
   if (RST) begin
      req_prev_r            <= 1'b0;
      start_r               <= 1'b0;
      BUSY                  <= 1'b0;
      input_data_buffer_r   <= 16'h0000;
      read_data_r           <= 16'h0000;
      cyc_type_r            <= `CYC_WORD_READ;
      cnt_en_r              <= 1'b0;
      adr_en_r              <= 1'b0;
      low_bit_r             <= 1'b0;
      HOST_CYCLE_TYPE       <= `CYC_WORD_READ;
      HOST_ADDR             <= `ADDR_RESET;
      HOST_WDATA            <= 16'h0000;
   end else begin
      req_prev_r <= request_level;
      start_r    <= accept;
      if (accept) begin
         BUSY                <= 1'b1; // R15
         input_data_buffer_r <= USER_INPUT_DATA; // R1
         cyc_type_r          <= {CYCLE_TYPE_BIT_HIGH, CYCLE_TYPE_BIT_LOW}; // R2
         cnt_en_r            <= COUNT_ADVANCE_ENABLE;
         adr_en_r            <= ADDRESS_ADVANCE_ENABLE;
         low_bit_r           <= BYTE_ADDRESS_LOW_BIT;
         HOST_CYCLE_TYPE     <= {CYCLE_TYPE_BIT_HIGH, CYCLE_TYPE_BIT_LOW}; // R2
         HOST_ADDR           <= {bus_addr_r[17:1], BYTE_ADDRESS_LOW_BIT}; // R11
         HOST_WDATA          <= USER_INPUT_DATA; // R1
      end else if (!BUSY) begin
         // idle buffer follows the pins so software sees live data
         input_data_buffer_r <= USER_INPUT_DATA; // R1
      end
      if (finish) begin
         BUSY <= 1'b0; // R15
         if (!cyc_type_r[1]) begin
            read_data_r <= HOST_RDATA;
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// control, count, address, error flags
always @(posedge MCLK or posedge RST) begin
   if (RST) begin
      run_r                       <= 1'b0;
      word_count_register_r       <= `WC_RESET;
      bus_addr_r                  <= `ADDR_RESET;
      user_attention_flag_r                 <= 1'b0;
      overlapping_request_error_r <= 1'b0;
   end else begin
      if (finish && cnt_en_r) begin
         word_count_register_r <= wc_next; // R6
         if (wc_next == 16'h0000) begin
            run_r <= 1'b0;
         end
      end
      if (finish && adr_en_r) begin
         bus_addr_r <= {bus_addr_r[17:1], low_bit_r} + `ADDR_STEP; // R8 R16
      end
      if (error_now) begin
         run_r <= 1'b0;
      end
      // software writes come first so hardware sets below win
      if (wr_fire && aw_addr_r == `OFS_CONTROL) begin
         if (w_strb_r[0]) begin
            run_r <= w_data_r[`CTL_GO_BIT];
            if (w_data_r[`CTL_GO_BIT]) begin
               // a new transfer clears the old error causes
               user_attention_flag_r                 <= 1'b0;
               overlapping_request_error_r <= 1'b0;
            end
         end
         if (w_strb_r[1] && !w_data_r[`CTL_USER_ATTENTION_BIT]) begin
            user_attention_flag_r <= 1'b0;
         end
      end
      if (wr_fire && aw_addr_r == `OFS_WORD_COUNT) begin
         word_count_register_r <= merged[15:0];
      end
      if (wr_fire && aw_addr_r == `OFS_BUS_ADDR) begin
         bus_addr_r <= merged[17:0];
      end
      // attention is taken only between cycles
      if (USER_ATTENTION && (!BUSY || finish)) begin
         user_attention_flag_r <= 1'b1; // R4
      end
      if (request_edge && BUSY) begin
         overlapping_request_error_r <= 1'b1; // R14
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// interrupts: sticky, write one to clear, set wins
always @(posedge MCLK or posedge RST) begin
   if (RST) begin
      irq_status_r <= 3'h0;
      irq_mask_r   <= 3'h0;
      IRQ          <= 1'b0;
   end else begin
      if (wr_fire && aw_addr_r == `OFS_IRQ_MASK && w_strb_r[0]) begin
         irq_mask_r <= w_data_r[2:0];
      end
      irq_status_r <= (irq_status_r &
                       ~((wr_fire && aw_addr_r == `OFS_IRQ_STATUS && w_strb_r[0]) ?
                         w_data_r[2:0] : 3'h0))
                      | {finish && cnt_en_r && wc_next == 16'h0000,
                         error_now, finish};
      IRQ <= |(irq_status_r & irq_mask_r);
   end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite write channel
always @(posedge MCLK or posedge RST) begin
   if (RST) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `RESP_OKAY;
      aw_addr_r     <= 5'h00;
      aw_have_r     <= 1'b0;
      w_data_r      <= 32'h00000000;
      w_strb_r      <= 4'h0;
      w_have_r      <= 1'b0;
   end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_addr_r     <= S_AXI_AWADDR;
         aw_have_r     <= 1'b1;
         S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_data_r     <= S_AXI_WDATA;
         w_strb_r     <= S_AXI_WSTRB;
         w_have_r     <= 1'b1;
         S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire) begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP  <= mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
         aw_have_r    <= 1'b0;
         w_have_r     <= 1'b0;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
         S_AXI_BVALID  <= 1'b0;
         S_AXI_AWREADY <= 1'b1;
         S_AXI_WREADY  <= 1'b1;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite read channel
always @(posedge MCLK or posedge RST) begin
   if (RST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `RESP_OKAY;
   end else begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b1;
         S_AXI_RRESP   <= mapped(S_AXI_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
         case (S_AXI_ARADDR)
            `OFS_CONTROL: begin
               S_AXI_RDATA <= {16'h0000,
                               error_now,                    // 15
                               burst_held,                   // 14
                               USER_ATTENTION,               // 13 R4
                               overlapping_request_error_r,  // 12
                               USER_STATUS,                  // 11:9 R5
                               BUSY,                         // 8
                               !run_r || error_now,          // 7 ready, R4
                               6'h00,
                               run_r};
            end
            `OFS_WORD_COUNT: S_AXI_RDATA <= {16'h0000, word_count_register_r};
            `OFS_BUS_ADDR:   S_AXI_RDATA <= {14'h0000, bus_addr_r};
            `OFS_INPUT_DATA: S_AXI_RDATA <= {16'h0000, input_data_buffer_r};
            `OFS_READ_DATA:  S_AXI_RDATA <= {16'h0000, read_data_r};
            `OFS_IRQ_STATUS: S_AXI_RDATA <= {29'h00000000, irq_status_r};
            `OFS_IRQ_MASK:   S_AXI_RDATA <= {29'h00000000, irq_mask_r};
            default:         S_AXI_RDATA <= 32'h00000000;
         endcase
      end
      if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID  <= 1'b0;
         S_AXI_ARREADY <= 1'b1;
      end
   end
end

// R7, R9, R10 and R12 are kept by the user device; the counters simply obey the pins
endmodule // dma_request_port

// [tb/dma_request_port_properties.sv]
// checker for the user-device dma port, bound to the top module
// assumes one clock MCLK and the active-high asynchronous reset RST
module dma_request_port_checker (
   input wire        MCLK,
   input wire        RST,
   input wire [15:0] USER_INPUT_DATA,
   input wire        CYCLE_TYPE_BIT_LOW,
   input wire        CYCLE_TYPE_BIT_HIGH,
   input wire        CYCLE_REQUEST_FIRST,
   input wire        CYCLE_REQUEST_SECOND,
   input wire        BYTE_ADDRESS_LOW_BIT,
   input wire        BURST_REQUEST_N,
   input wire        BUSY,
   input wire        DMA_BUS_REQUEST,
   input wire        HOST_CYCLE,
   input wire [1:0]  HOST_CYCLE_TYPE,
   input wire [17:0] HOST_ADDR,
   input wire [15:0] HOST_WDATA,
   input wire        HOST_DONE
);
   timeunit 1ns;
   timeprecision 1ps;
   wire req_any = CYCLE_REQUEST_FIRST | CYCLE_REQUEST_SECOND;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   ////////////////////////////////////////
   // busy rises only one cycle after a request edge
   busy_on_req_a: assert property ($rose(BUSY) |-> $past(req_any) && !$past(req_any, 2))
      else $error("busy rose without a request edge");
   cycle_type_a: assert property ($rose(BUSY) |->
      HOST_CYCLE_TYPE == $past({CYCLE_TYPE_BIT_HIGH, CYCLE_TYPE_BIT_LOW}))
      else $error("host cycle type differs from pins");
   low_addr_a: assert property ($rose(BUSY) |-> HOST_ADDR[0] == $past(BYTE_ADDRESS_LOW_BIT))
      else $error("host address bit0 differs from pin");
   write_data_a: assert property ($rose(BUSY) |-> HOST_WDATA == $past(USER_INPUT_DATA))
      else $error("host write data differs from pins");
   cycle_busy_a: assert property (HOST_CYCLE |-> BUSY)
      else $error("host cycle without busy");
   busy_end_a: assert property (HOST_CYCLE && HOST_DONE |=> !HOST_CYCLE ##1 !BUSY)
      else $error("busy not released after cycle end");
   bus_req_a: assert property ($rose(BUSY) |=> DMA_BUS_REQUEST || HOST_CYCLE)
      else $error("no bus request after accept");
   burst_drop_a: assert property (HOST_CYCLE && HOST_DONE && BURST_REQUEST_N
      |-> ##[1:2] !DMA_BUS_REQUEST)
      else $error("bus request kept without burst");
   cover property ($rose(BUSY) && HOST_CYCLE_TYPE == 2'h3);
   cover property (HOST_CYCLE && HOST_DONE && !BURST_REQUEST_N);
   cover property (BUSY && $rose(req_any));
endmodule // dma_request_port_checker

bind dma_request_port dma_request_port_checker dma_request_port_checker_inst (
   .MCLK(MCLK), .RST(RST), .USER_INPUT_DATA(USER_INPUT_DATA),
   .CYCLE_TYPE_BIT_LOW(CYCLE_TYPE_BIT_LOW), .CYCLE_TYPE_BIT_HIGH(CYCLE_TYPE_BIT_HIGH),
   .CYCLE_REQUEST_FIRST(CYCLE_REQUEST_FIRST), .CYCLE_REQUEST_SECOND(CYCLE_REQUEST_SECOND),
   .BYTE_ADDRESS_LOW_BIT(BYTE_ADDRESS_LOW_BIT), .BURST_REQUEST_N(BURST_REQUEST_N),
   .BUSY(BUSY), .DMA_BUS_REQUEST(DMA_BUS_REQUEST), .HOST_CYCLE(HOST_CYCLE),
   .HOST_CYCLE_TYPE(HOST_CYCLE_TYPE), .HOST_ADDR(HOST_ADDR), .HOST_WDATA(HOST_WDATA),
   .HOST_DONE(HOST_DONE));

// [tb/user_device_model.sv]
// user-device model: data, cycle type, request lines and step enables
// assumes the clock of the port and its BUSY output
module user_device_model (
   input  wire        clk,
   input  wire        busy,
   output reg  [15:0] data,
   output reg         typ_lo,
   output reg         typ_hi,
   output reg         req_first,
   output reg         req_second,
   output reg         wc_en,
   output reg         ba_en,
   output reg         low
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {data, typ_lo, typ_hi, req_first, req_second, wc_en, ba_en, low} = '0;
   end
   ////////////////////////////////////////
   // pause and even-byte cycles never step count or address
   task automatic setup(input logic [1:0] t, input logic [15:0] d, input logic w, b, l);
      logic hold;
      hold = (t == 2'h1) || (t == 2'h3 && !l);
      @(posedge clk);
      data <= d;
      typ_hi <= t[1];
      typ_lo <= t[0];
      wc_en <= w && !hold;
      ba_en <= b && !hold;
      low <= l && t == 2'h3;
   endtask
   // gives up after 20 cycles: an ignored request never shows busy
   task automatic request(input logic second);
      int n;
      n = 0;
      @(posedge clk);
      if (second)
         req_second <= 1'b1;
      else
         req_first <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (busy !== 1'b1 && n < 20);
      req_first <= 1'b0;
      req_second <= 1'b0;
   endtask
endmodule // user_device_model

// [tb/dma_request_port_tb_top.sv]
// bench for the user-device dma port: axi register tasks, host bus responder
// assumes the user-device model drives the user data and request pins
`include "dma_port_consts.vh"
module dma_request_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [4:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r, htype;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [15:0] udata, hwdata, hrdata, exp_wc;
   logic [17:0] haddr, exp_ba;
   logic [2:0]  status;
   logic        tlo, thi, rqa, rqb, user_attention, wce, bae, low, burst_n, busy;
   logic        hreq, grant, hcyc, hdone, irq, grant_en;
   int          n_mismatch = 0;
   int          samples_checked = 0;
   int          slow = 0;
   int          dwell = 0;
   localparam logic [15:0] RD_WORD = 16'hA5C3;
   always #2 mclk = ~mclk;
   dma_request_port dma_request_port_inst (
      .MCLK(mclk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .USER_INPUT_DATA(udata), .CYCLE_TYPE_BIT_LOW(tlo), .CYCLE_TYPE_BIT_HIGH(thi),
      .CYCLE_REQUEST_FIRST(rqa), .CYCLE_REQUEST_SECOND(rqb), .USER_ATTENTION(user_attention),
      .USER_STATUS(status), .COUNT_ADVANCE_ENABLE(wce), .ADDRESS_ADVANCE_ENABLE(bae),
      .BYTE_ADDRESS_LOW_BIT(low), .BURST_REQUEST_N(burst_n), .BUSY(busy),
      .DMA_BUS_REQUEST(hreq), .HOST_GRANT(grant), .HOST_CYCLE(hcyc),
      .HOST_CYCLE_TYPE(htype), .HOST_ADDR(haddr), .HOST_WDATA(hwdata),
      .HOST_RDATA(hrdata), .HOST_DONE(hdone), .IRQ(irq));
   user_device_model user_device_model_inst (
      .clk(mclk), .busy(busy), .data(udata), .typ_lo(tlo), .typ_hi(thi),
      .req_first(rqa), .req_second(rqb), .wc_en(wce), .ba_en(bae), .low(low));
   ////////////////////////////////////////
   // host bus: grant follows request, done after slow cycles of dwell
   always @(posedge mclk) begin
      grant <= hreq && grant_en;
      hdone <= hcyc && !hdone && dwell >= slow;
      dwell <= hcyc ? dwell + 1 : 0;
      hrdata <= hcyc ? RD_WORD : ~hrdata;
   end
   task automatic give_verdict;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic axi_write(input logic [4:0] a, input logic [31:0] v);
      @(posedge mclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= v;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge mclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
            break;
      end
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_read(input logic [4:0] a);
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge mclk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
            break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      axi_read(a);
      check(d & m, e);
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 200) begin
         @(posedge mclk);
         n++;
      end
   endtask
   task automatic xfer(input logic [1:0] t, input logic [15:0] v, input logic w, b, l, s);
      user_device_model_inst.setup(t, v, w, b, l);
      user_device_model_inst.request(s);
      wait_idle;
   endtask
   initial begin
      repeat (5000) @(posedge mclk);
      n_mismatch++;
      give_verdict;
   end
   ////////////////////////////////////////
   initial begin
      {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
      user_attention = 1'b0;
      wstrb = 4'hF;
      status = 3'h5;
      burst_n = 1'b1;
      grant_en = 1'b1;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      rd_chk(`OFS_CONTROL, 32'hFFFFFFFF, 32'h00000A80);
      axi_read(5'h1C);
      check(r, `RESP_SLVERR);
      axi_write(5'h1C, 32'h1);
      check(r, `RESP_SLVERR);
      axi_write(`OFS_WORD_COUNT, 32'h0);
      axi_write(`OFS_BUS_ADDR, 32'h100);
      axi_write(`OFS_CONTROL, 32'h1);
      exp_wc = `WC_RESET;
      exp_ba = 18'h00100;
      for (int i = 0; i < 4; i++) begin
         xfer(i[1:0], {14'h048C, i[1:0]}, 1'b1, 1'b1, i == 3, i[0]);
         if (i != 1) begin
            exp_wc = exp_wc + 16'h0001;
            exp_ba = {exp_ba[17:1], i == 3} + `ADDR_STEP;
         end
         rd_chk(`OFS_WORD_COUNT, 32'hFFFF, {16'h0, exp_wc});
         rd_chk(`OFS_BUS_ADDR, 32'h3FFFF, {14'h0, exp_ba});
         rd_chk(`OFS_INPUT_DATA, 32'hFFFF, {18'h0, 12'h48C, i[1:0]});
      end
      check(haddr, 18'h00105);
      rd_chk(`OFS_READ_DATA, 32'hFFFF, {16'h0, RD_WORD});
      // interrupt: pending but masked, then unmasked, then cleared
      check(irq, 1'b0);
      rd_chk(`OFS_IRQ_STATUS, 32'h1, 32'h1);
      axi_write(`OFS_IRQ_MASK, 32'h7);
      repeat (2) @(posedge mclk);
      check(irq, 1'b1);
      axi_write(`OFS_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge mclk);
      check(irq, 1'b0);
      xfer(2'h2, 16'h0F0F, 1'b1, 1'b0, 1'b0, 1'b0);
      xfer(2'h2, 16'hF0F0, 1'b1, 1'b0, 1'b0, 1'b1);
      rd_chk(`OFS_WORD_COUNT, 32'hFFFF, {16'h0, exp_wc + 16'h0002});
      rd_chk(`OFS_BUS_ADDR, 32'h3FFFF, {14'h0, exp_ba});
      // second request while the first waits for the bus
      grant_en <= 1'b0;
      user_device_model_inst.setup(2'h2, 16'h5555, 1'b1, 1'b1, 1'b0);
      user_device_model_inst.request(1'b0);
      user_device_model_inst.request(1'b1);
      rd_chk(`OFS_CONTROL, 32'h9180, 32'h9180);
      grant_en <= 1'b1;
      wait_idle;
      axi_write(`OFS_CONTROL, 32'h1);
      rd_chk(`OFS_CONTROL, 32'hFFFF, 32'h0A01);
      // attention mid-cycle only flags once the cycle is over
      grant_en <= 1'b0;
      user_device_model_inst.setup(2'h0, 16'h0, 1'b0, 1'b0, 1'b0);
      user_device_model_inst.request(1'b0);
      user_attention <= 1'b1;
      rd_chk(`OFS_CONTROL, 32'hA000, 32'h2000);
      grant_en <= 1'b1;
      wait_idle;
      rd_chk(`OFS_CONTROL, 32'hA081, 32'hA080);
      xfer(2'h2, 16'h0, 1'b1, 1'b1, 1'b0, 1'b0);
      rd_chk(`OFS_WORD_COUNT, 32'hFFFF, {16'h0, exp_wc + 16'h0003});
      user_attention <= 1'b0;
      axi_write(`OFS_CONTROL, 32'h1);
      rd_chk(`OFS_CONTROL, 32'h8000, 32'h0);
      burst_n <= 1'b0;
      xfer(2'h2, 16'h1111, 1'b1, 1'b1, 1'b0, 1'b0);
      xfer(2'h2, 16'h1111, 1'b1, 1'b1, 1'b0, 1'b1);
      check(hreq, 1'b1);
      rd_chk(`OFS_CONTROL, 32'h4000, 32'h4000);
      slow = 3;
      burst_n <= 1'b1;
      xfer(2'h3, 16'h2222, 1'b1, 1'b1, 1'b1, 1'b0);
      check(hreq, 1'b0);
      axi_write(`OFS_WORD_COUNT, 32'hFFFF);
      xfer(2'h2, 16'h3333, 1'b1, 1'b1, 1'b0, 1'b1);
      rd_chk(`OFS_WORD_COUNT, 32'hFFFF, 32'h0);
      rd_chk(`OFS_CONTROL, 32'h1, 32'h0);
      rd_chk(`OFS_IRQ_STATUS, 32'h4, 32'h4);
      give_verdict;
   end
endmodule // dma_request_port_tb_top
